// File: verilog/tlp_pkg.sv
/*
 * Constants shared by the two-level interrupt priority controller: vector addresses,
 * control bit positions, reset values, latency figures and the service state type.
 * Assumes a core whose clock is the instruction clock, one instruction cycle per edge.
 */
// Function
// [R1] High vector sits at 0008h, low vector at 0018h.
// [R2] In priority mode a high request preempts a running low routine.
// [R3] Every source owns a flag, an enable and a priority select.
// [R4] Two-level scheme only while priority_mode_enable (reset control bit 7) is set.
// [R5] Priority mode: high-level global enable (bit 7) gates high sources.
// [R6] Priority mode: low-level global enable (bit 6) gates low sources.
// [R7] Flag, enable and applicable global enable set: vector at once by priority.
// [R8] priority_mode_enable resets cleared; then priority bits are ignored.
// [R9] Compatibility mode: bit 6 is peripheral enable for all peripheral sources.
// [R10] Compatibility mode: bit 7 is one global enable for every source.
// [R11] Compatibility mode: every accepted request goes to 0008h.
// [R12] Acceptance clears the global enable that admitted the request.
// [R13] No low request is taken while a high routine runs.
// [R14] Acceptance pushes the return address and loads the vector into the PC.
// [R15] Software clears serviced flags before enabling again, else it recurs.
// [R16] Return from interrupt leaves the routine and sets the proper enable again.
// [R17] Pin and port change latency is three to four cycles, any instruction.
// [R18] Flags set on their event regardless of any enable.
// [R19] Software avoids the memory-to-memory move on control while enabled.
// [R20] Each external pin has edge select: one rising, zero falling.
// [R21] High and low eligible together: high is taken first with high vector.
package tlp_pkg;

    localparam int PC_W = 21;
    localparam logic [PC_W-1:0] VEC_HIGH_ADDR = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW_ADDR = 21'h000018;

    localparam int CTRL_W = 8;
    localparam int MAIN_HI_BIT = 7;
    localparam int MAIN_LO_BIT = 6;
    localparam int RCTL_PME_BIT = 7;

    localparam logic RESET_PME = 1'b0;
    localparam logic RESET_GIE = 1'b0;
    localparam logic [CTRL_W-1:0] CTRL_ZERO = 8'h00;

    // pin to vector latency in instruction cycles
    localparam int LAT_MIN_CYC = 3;
    localparam int LAT_MAX_CYC = 4;

    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_LOW,
        SVC_HIGH,
        SVC_HIGH_NEST
    } tlp_svc_type;

endpackage : tlp_pkg

// File: verilog/tlp_edge_sync.sv
/*
 * Two-flop synchroniser for a group of pins, with per-pin edge select and a
 * change output. Pins are asynchronous to clock_i; outputs are one-cycle pulses.
 */
`timescale 1ns/1ps
module tlp_edge_sync
    import tlp_pkg::*;
#(
    parameter int W = 3
)
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] rise_sel_i,
    output logic [W-1:0] edge_o,
    output logic [W-1:0] change_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } tlp_sync_type;

    tlp_sync_type r;
    tlp_sync_type next_r;

    // shift chain: s1 is only read by s2
    always_comb
    begin
        next_r = r;
        next_r.s1 = pin_i;
        next_r.s2 = r.s1;
        next_r.prev = r.s2;
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // [R20] edge select decode
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_edge
            assign edge_o[g] = rise_sel_i[g] ? (r.s2[g] & ~r.prev[g]) : (~r.s2[g] & r.prev[g]);
        end
    endgenerate

    assign change_o = r.s2 ^ r.prev;

endmodule : tlp_edge_sync

// File: verilog/tlp_select.sv
/*
 * Combinational eligibility of high and low level requests from the flag,
 * enable and priority vectors and the global enables. No state of its own.
 */
`timescale 1ns/1ps
module tlp_select
    import tlp_pkg::*;
#(
    parameter int N = 16
)
(
    input wire logic [N-1:0] flag_i,
    input wire logic [N-1:0] enable_i,
    input wire logic [N-1:0] prio_i,
    input wire logic [N-1:0] periph_i,
    input wire logic pme_i,
    input wire logic gie_hi_i,
    input wire logic gie_lo_i,
    output logic hi_req_o,
    output logic lo_req_o
);

    function automatic logic any_set(input logic [N-1:0] v, input logic [N-1:0] m);
        any_set = |(v & m);
    endfunction : any_set

    logic [N-1:0] pend;

    // [R3] flag and enable per source
    assign pend = flag_i & enable_i;

    always_comb
    begin
        if (pme_i)
        begin
            // [R5] high level gate
            hi_req_o = gie_hi_i & any_set(pend, prio_i);
            // [R6] low level gate, high enable off blocks all
            lo_req_o = gie_hi_i & gie_lo_i & any_set(pend, ~prio_i);
        end
        else
        begin
            // [R8] priority ignored; [R9] [R10] peripheral and global gates
            hi_req_o = gie_hi_i & any_set(pend, ~periph_i | {N{gie_lo_i}});
            lo_req_o = 1'b0;
        end
    end

endmodule : tlp_select

// File: verilog/tlp_ctrl.sv
/*
 * Two-level interrupt priority controller. Holds the flags, global enables and
 * mode bit, accepts requests, vectors the core and restores enables on return.
 * Assumes the core takes vector_o in the cycle it is high: it pushes stack_data_o
 * and loads vector_addr_o. Control ports come from core register writes on clock_i.
 */
`timescale 1ns/1ps
module tlp_ctrl
    import tlp_pkg::*;
#(
    parameter int N_SRC = 16,
    parameter int NUM_EXT = 3,
    parameter int PORT_W = 4,
    parameter int PORT_SRC = 3,
    parameter logic [N_SRC-1:0] PERIPH_MASK = 16'hfff0
)
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [NUM_EXT-1:0] ext_pin_i,
    input wire logic [NUM_EXT-1:0] ext_irq_edge_select_i,
    input wire logic [PORT_W-1:0] port_pin_i,
    input wire logic [N_SRC-1:0] event_i,
    input wire logic [N_SRC-1:0] flag_clr_i,
    input wire logic [N_SRC-1:0] enable_i,
    input wire logic [N_SRC-1:0] prio_i,
    input wire logic main_irq_control_reg_wr_i,
    input wire logic [CTRL_W-1:0] main_irq_control_reg_wdata_i,
    input wire logic reset_control_reg_wr_i,
    input wire logic [CTRL_W-1:0] reset_control_reg_wdata_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic return_from_irq_instr_i,
    output logic [N_SRC-1:0] flags_o,
    output logic [CTRL_W-1:0] main_irq_control_reg_rdata_o,
    output logic priority_mode_enable_o,
    output logic vector_o,
    output logic [PC_W-1:0] vector_addr_o,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_data_o,
    output logic in_high_service_o,
    output logic in_low_service_o
);

    typedef struct packed {
        logic [N_SRC-1:0] flags;
        logic gie_hi;
        logic gie_lo;
        logic pme;
        tlp_svc_type svc;
        logic vec_pulse;
        logic [PC_W-1:0] vec_addr;
        logic [PC_W-1:0] push_data;
    } tlp_state_type;

    tlp_state_type r;
    tlp_state_type next_r;

    logic [NUM_EXT-1:0] ext_edge;
    logic [PORT_W-1:0] port_change;
    logic [N_SRC-1:0] pin_events;
    logic [N_SRC-1:0] all_events;
    logic hi_req;
    logic lo_req;
    logic can_accept;
    logic take_hi;
    logic take_lo;

    // [R20] external pins synchronised, edge chosen per pin
    tlp_edge_sync #(
        .W(NUM_EXT)
    ) u_ext_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .pin_i(ext_pin_i),
        .rise_sel_i(ext_irq_edge_select_i),
        .edge_o(ext_edge),
        .change_o()
    );

    // port change source: any pin of the group toggling
    tlp_edge_sync #(
        .W(PORT_W)
    ) u_port_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .pin_i(port_pin_i),
        .rise_sel_i({PORT_W{1'b1}}),
        .edge_o(),
        .change_o(port_change)
    );

    // map pin events onto their source slots
    always_comb
    begin
        pin_events = '0;
        pin_events[NUM_EXT-1:0] = ext_edge;
        pin_events[PORT_SRC] = |port_change;
    end

    assign all_events = event_i | pin_events;

    // eligibility against the enables currently held
    tlp_select #(
        .N(N_SRC)
    ) u_select (
        .flag_i(r.flags),
        .enable_i(enable_i),
        .prio_i(prio_i),
        .periph_i(PERIPH_MASK),
        .pme_i(r.pme),
        .gie_hi_i(r.gie_hi),
        .gie_lo_i(r.gie_lo),
        .hi_req_o(hi_req),
        .lo_req_o(lo_req)
    );

    // no acceptance while software writes the enables, on a return, or right after a vector
    assign can_accept = !main_irq_control_reg_wr_i && !return_from_irq_instr_i && !r.vec_pulse;

    // [R2] high may enter idle or a low routine; [R21] high wins a tie
    assign take_hi = can_accept && hi_req && (r.svc == SVC_IDLE || r.svc == SVC_LOW);
    // [R13] low only from idle
    assign take_lo = can_accept && lo_req && !take_hi && (r.svc == SVC_IDLE);

    // next state of flags, enables, service level and vector outputs
    always_comb
    begin
        next_r = r;
        next_r.vec_pulse = 1'b0;
        // [R18] set regardless of enables; set wins over clear
        next_r.flags = (r.flags & ~flag_clr_i) | all_events;
        // software writes of the enable bits
        if (main_irq_control_reg_wr_i)
        begin
            next_r.gie_hi = main_irq_control_reg_wdata_i[MAIN_HI_BIT];
            next_r.gie_lo = main_irq_control_reg_wdata_i[MAIN_LO_BIT];
        end
        // [R4] mode bit from reset control register
        if (reset_control_reg_wr_i)
        begin
            next_r.pme = reset_control_reg_wdata_i[RCTL_PME_BIT];
        end
        // [R16] return re-arms the enable of the level left
        if (return_from_irq_instr_i)
        begin
            unique case (r.svc)
                SVC_IDLE:
                begin
                    next_r.gie_hi = 1'b1;
                end
                SVC_LOW:
                begin
                    if (r.pme)
                    begin
                        next_r.gie_lo = 1'b1;
                    end
                    else
                    begin
                        next_r.gie_hi = 1'b1;
                    end
                    next_r.svc = SVC_IDLE;
                end
                SVC_HIGH:
                begin
                    next_r.gie_hi = 1'b1;
                    next_r.svc = SVC_IDLE;
                end
                SVC_HIGH_NEST:
                begin
                    next_r.gie_hi = 1'b1;
                    next_r.svc = SVC_LOW;
                end
            endcase
        end
        if (take_hi)
        begin
            // [R12] clear the enable that admitted it
            next_r.gie_hi = 1'b0;
            next_r.svc = (r.svc == SVC_LOW) ? SVC_HIGH_NEST : SVC_HIGH;
            // [R1] [R11] high vector, also the only one in compatibility mode
            next_r.vec_addr = VEC_HIGH_ADDR;
        end
        else if (take_lo)
        begin
            // [R12] low enable cleared
            next_r.gie_lo = 1'b0;
            next_r.svc = SVC_LOW;
            // [R1] [R7] low vector
            next_r.vec_addr = VEC_LOW_ADDR;
        end
        // [R14] push return address with the vector load
        if (take_hi || take_lo)
        begin
            next_r.vec_pulse = 1'b1;
            next_r.push_data = pc_i;
        end
    end

    // [R8] mode and enables reset cleared
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r.flags <= '0;
            r.gie_hi <= RESET_GIE;
            r.gie_lo <= RESET_GIE;
            r.pme <= RESET_PME;
            r.svc <= SVC_IDLE;
            r.vec_pulse <= 1'b0;
            r.vec_addr <= VEC_HIGH_ADDR;
            r.push_data <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // [R17] pin to vector: two sync edges, flag edge, vector edge
    assign vector_o = r.vec_pulse;
    assign stack_push_o = r.vec_pulse;
    assign vector_addr_o = r.vec_addr;
    assign stack_data_o = r.push_data;
    assign flags_o = r.flags;
    assign priority_mode_enable_o = r.pme;
    assign in_high_service_o = (r.svc == SVC_HIGH) || (r.svc == SVC_HIGH_NEST);
    assign in_low_service_o = (r.svc == SVC_LOW) || (r.svc == SVC_HIGH_NEST);

    // read view of the two enable bits, other bits zero
    always_comb
    begin
        main_irq_control_reg_rdata_o = CTRL_ZERO;
        main_irq_control_reg_rdata_o[MAIN_HI_BIT] = r.gie_hi;
        main_irq_control_reg_rdata_o[MAIN_LO_BIT] = r.gie_lo;
    end

endmodule : tlp_ctrl

// File: tb/tlp_ctrl_asserts.sv
/*
 * Port checker for tlp_ctrl: vector pulses, enable clearing and restore, nesting.
 * Assumes one clock domain and the asynchronous active-low reset of the block.
 */
`timescale 1ns/1ps
module tlp_ctrl_chk
    import tlp_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic reset_control_reg_wr_i,
    input wire logic [CTRL_W-1:0] reset_control_reg_wdata_i,
    input wire logic return_from_irq_instr_i,
    input wire logic [CTRL_W-1:0] main_irq_control_reg_rdata_o,
    input wire logic priority_mode_enable_o,
    input wire logic vector_o,
    input wire logic [PC_W-1:0] vector_addr_o,
    input wire logic stack_push_o,
    input wire logic in_high_service_o,
    input wire logic in_low_service_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    // short names for the control read-back and the two vector kinds
    wire logic [CTRL_W-1:0] ctl = main_irq_control_reg_rdata_o;
    wire logic hv = vector_o && vector_addr_o == VEC_HIGH_ADDR;
    wire logic lv = vector_o && vector_addr_o == VEC_LOW_ADDR;

    a_vec_single: assert property (vector_o |=> !vector_o)
        else $error("vector pulse longer than one cycle");
    a_vec_push: assert property (vector_o |-> stack_push_o && (hv || lv))
        else $error("vector without push or with a bad address");
    a_compat_vec: assert property (vector_o && !priority_mode_enable_o |-> hv)
        else $error("compatibility vector not at high address");
    a_high_entry: assert property (hv |-> !ctl[MAIN_HI_BIT] && in_high_service_o)
        else $error("high entry left its enable set");
    a_low_entry: assert property (lv |-> !ctl[MAIN_LO_BIT] && in_low_service_o)
        else $error("low entry left its enable set");
    a_no_low_nest: assert property (in_high_service_o |=> !lv)
        else $error("low vector during high service");
    a_ret_high: assert property (return_from_irq_instr_i && in_high_service_o
        |=> ctl[MAIN_HI_BIT])
        else $error("return did not restore high enable");
    a_ret_low: assert property (return_from_irq_instr_i && !in_high_service_o
        && in_low_service_o |=> ctl[MAIN_LO_BIT])
        else $error("return did not restore low enable");
    a_mode_write: assert property (reset_control_reg_wr_i |=> priority_mode_enable_o
        == $past(reset_control_reg_wdata_i[RCTL_PME_BIT]))
        else $error("mode bit not taken from write");

    // main scenarios reached
    c_low_vec: cover property (lv);
    c_nested: cover property (in_high_service_o && in_low_service_o);
    c_ret_low: cover property (return_from_irq_instr_i && in_low_service_o);
endmodule : tlp_ctrl_chk

bind tlp_ctrl tlp_ctrl_chk u_tlp_ctrl_chk (.clock_i, .reset_n_i, .reset_control_reg_wr_i,
    .reset_control_reg_wdata_i, .return_from_irq_instr_i, .main_irq_control_reg_rdata_o,
    .priority_mode_enable_o, .vector_o, .vector_addr_o, .stack_push_o, .in_high_service_o,
    .in_low_service_o);

// File: tb/tlp_core_model.sv
/*
 * Core sequencer model: program counter, eight-deep return stack, return pulse.
 * Assumes the controller's push and vector outputs and a bench return request.
 */
`timescale 1ns/1ps
module tlp_core_model
    import tlp_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic stack_push_i,
    input wire logic [PC_W-1:0] vector_addr_i,
    input wire logic [PC_W-1:0] stack_data_i,
    input wire logic ret_req_i,
    output logic [PC_W-1:0] pc_o,
    output logic [PC_W-1:0] last_pc_o,
    output logic return_o,
    output logic [2:0] depth_o
);
    logic [PC_W-1:0] stk [0:7];

    // program steps by two; a push jumps to the vector, a return pops
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_o <= 21'h000100;
            last_pc_o <= 21'h000000;
            return_o <= 1'b0;
            depth_o <= 3'h0;
        end
        else
        begin
            last_pc_o <= pc_o;
            return_o <= ret_req_i;
            if (stack_push_i)
            begin
                stk[depth_o] <= stack_data_i;
                depth_o <= depth_o + 3'h1;
                pc_o <= vector_addr_i;
            end
            else if (return_o)
            begin
                depth_o <= depth_o - 3'h1;
                pc_o <= stk[depth_o - 3'h1];
            end
            else
            begin
                pc_o <= pc_o + 21'h000002;
            end
        end
    end
endmodule : tlp_core_model

// File: tb/test_tlp_ctrl.sv
/*
 * Bench for tlp_ctrl: sources, pins and control writes in compatibility and
 * priority mode. Assumes default parameters and the tlp_core_model partner.
 */
`timescale 1ns/1ps
module test_tlp_ctrl
    import tlp_pkg::*;
;
    logic clock_i, reset_n_i, wr_m, wr_r, ret_req, ret, vec, push, pme, in_hi, in_lo;
    logic [2:0] pin, esel, depth;
    logic [3:0] ppin;
    logic [15:0] ev, clr, en, pr, flags;
    logic [7:0] wd_m, wd_r, rd;
    logic [PC_W-1:0] pc, last_pc, vaddr, sdata;
    int err_total, checks_done, n;

    tlp_ctrl u_tlp_ctrl (.clock_i, .reset_n_i, .ext_pin_i(pin), .ext_irq_edge_select_i(esel),
        .port_pin_i(ppin), .event_i(ev), .flag_clr_i(clr), .enable_i(en), .prio_i(pr),
        .main_irq_control_reg_wr_i(wr_m), .main_irq_control_reg_wdata_i(wd_m),
        .reset_control_reg_wr_i(wr_r), .reset_control_reg_wdata_i(wd_r), .pc_i(pc),
        .return_from_irq_instr_i(ret), .flags_o(flags), .main_irq_control_reg_rdata_o(rd),
        .priority_mode_enable_o(pme), .vector_o(vec), .vector_addr_o(vaddr),
        .stack_push_o(push), .stack_data_o(sdata), .in_high_service_o(in_hi),
        .in_low_service_o(in_lo));
    tlp_core_model u_tlp_core_model (.clock_i, .reset_n_i, .stack_push_i(push),
        .vector_addr_i(vaddr), .stack_data_i(sdata), .ret_req_i(ret_req), .pc_o(pc),
        .last_pc_o(last_pc), .return_o(ret), .depth_o(depth));

    // bench helpers: compare, step, pulses, waits
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask : step
    task automatic pulse_ev(input logic [15:0] m);
        ev = m;
        step(1);
        ev = 16'h0000;
    endtask : pulse_ev
    // enables change by single control writes, never memory-to-memory moves
    task automatic wr_main(input logic [7:0] v);
        wd_m = v;
        wr_m = 1'b1;
        step(1);
        wr_m = 1'b0;
    endtask : wr_main
    task automatic svc_end(input logic [15:0] m);
        clr = m;
        ret_req = 1'b1;
        step(1);
        clr = 16'h0000;
        ret_req = 1'b0;
        step(1);
    endtask : svc_end
    task automatic quiet(input int k);
        repeat (k)
        begin
            step(1);
            chk("no_vector", 0, vec);
        end
    endtask : quiet
    task automatic wait_vec(input logic [PC_W-1:0] a);
        n = 0;
        while (vec !== 1'b1 && n < 12)
        begin
            step(1);
            n++;
        end
        if (vec !== 1'b1)
        begin
            err_total++;
            tally_and_finish();
        end
        chk("vector_addr", a, vaddr);
        chk("stack_data", last_pc, sdata);
    endtask : wait_vec
    task automatic lat_svc(input logic [15:0] m);
        wait_vec(VEC_HIGH_ADDR);
        chk("latency", 1, n >= LAT_MIN_CYC && n <= LAT_MAX_CYC);
        svc_end(m);
    endtask : lat_svc
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // clock
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // main sequence
    initial
    begin
        {reset_n_i, wr_m, wr_r, ret_req} = 4'h0;
        {pin, ppin, wd_m, wd_r} = '0;
        {ev, clr, en, pr} = '0;
        esel = 3'h1;
        repeat (8) @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        step(1);
        chk("mode", 0, pme);
        chk("ctl", 0, rd);
        pulse_ev(16'h0020);
        chk("flags", 16'h0020, flags);
        en = 16'hffff;
        pr = 16'h0020;
        wr_main(8'h80);
        quiet(6);
        pulse_ev(16'h0002);
        wait_vec(VEC_HIGH_ADDR);
        chk("ctl", 8'h00, rd);
        svc_end(16'h0022);
        chk("ctl", 8'h80, rd);
        wr_main(8'hc0);
        pulse_ev(16'h0020);
        wait_vec(VEC_HIGH_ADDR);
        svc_end(16'h0020);
        pin[0] = 1'b1;
        lat_svc(16'h0001);
        pin[1] = 1'b1;
        quiet(6);
        pin[1] = 1'b0;
        lat_svc(16'h0002);
        ppin[2] = 1'b1;
        lat_svc(16'h0008);
        wd_r = 8'h80;
        wr_r = 1'b1;
        step(1);
        wr_r = 1'b0;
        chk("mode", 1, pme);
        pr = 16'h0002;
        pulse_ev(16'h0100);
        wait_vec(VEC_LOW_ADDR);
        chk("ctl", 8'h80, rd);
        pulse_ev(16'h0002);
        wait_vec(VEC_HIGH_ADDR);
        chk("svc", 2'b11, {in_hi, in_lo});
        pulse_ev(16'h0200);
        chk("depth", 2, depth);
        quiet(6);
        svc_end(16'h0002);
        chk("ctl", 8'h80, rd);
        svc_end(16'h0100);
        chk("ctl", 8'hc0, rd);
        wait_vec(VEC_LOW_ADDR);
        svc_end(16'h0200);
        pulse_ev(16'h0102);
        wait_vec(VEC_HIGH_ADDR);
        svc_end(16'h0002);
        wait_vec(VEC_LOW_ADDR);
        svc_end(16'h0100);
        wr_main(8'h40);
        pulse_ev(16'h0002);
        quiet(6);
        wr_main(8'h80);
        wait_vec(VEC_HIGH_ADDR);
        svc_end(16'h0002);
        chk("ctl", 8'h80, rd);
        en = 16'hfffd;
        pulse_ev(16'h0002);
        quiet(6);
        en = 16'hffff;
        wait_vec(VEC_HIGH_ADDR);
        svc_end(16'h0002);
        tally_and_finish();
    end
endmodule : test_tlp_ctrl
